/* rtl/ddcnco_accum.sv */
// Phase accumulator for the active channel; adds a signed increment on each sample enable.
module ddcnco_accum #(
    parameter int ACC_W = 48,
    parameter int INC_W = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             sample_en,
    input  wire logic [INC_W-1:0] increment,
    output logic      [ACC_W-1:0] phase
);
    logic [ACC_W-1:0] phase_q;
    logic [ACC_W-1:0] phase_d;
    logic [ACC_W-1:0] inc_ext;

    ////////////////////////////////////////////////////////////////////////
    // Sign extension lets a negative word tune below zero; wrap is free modulo 2^48.
    always_comb begin
        inc_ext = {{(ACC_W-INC_W){increment[INC_W-1]}}, increment};
        phase_d = phase_q;
        if (sample_en) begin
            phase_d = phase_q + inc_ext;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;

    AST_ACC_ADD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sample_en |=> phase_q == $past(phase_q) + $past(inc_ext))
        else $error("Accumulator did not add the increment.");
    AST_ACC_SIGN: assert property (@(posedge clk_sys) disable iff (sys_rst)
        inc_ext[ACC_W-1] == increment[INC_W-1])
        else $error("Increment not sign extended.");
endmodule

/* rtl/ddcnco_pkg.sv */
package ddcnco_pkg;
    // Register indices; the byte address of each register is four times its index.
    localparam logic [11:0] IDX_OSC_CTRL     = 12'h334;
    localparam logic [11:0] IDX_PHASE_UPDATE = 12'h335;
    localparam logic [11:0] IDX_TUNE_BYTE0   = 12'h336;
    localparam logic [11:0] IDX_TUNE_BYTE1   = 12'h337;
    localparam logic [11:0] IDX_TUNE_BYTE2   = 12'h338;
    localparam logic [11:0] IDX_TUNE_BYTE3   = 12'h339;
    localparam logic [11:0] IDX_XFER_CMD     = 12'h33C;
    localparam logic [11:0] IDX_STATUS       = 12'h33D;
    // Field positions and widths.
    localparam int          SEL_LSB          = 0;
    localparam int          SRC_LSB          = 4;
    localparam int          FIELD_W          = 4;
    localparam int          ACC_W            = 48;
    localparam int          TUNE_W           = 32;
    localparam int          NUM_CHAN         = 16;
    // Reset values.
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [3:0]  RST_FIELD        = 4'h0;
    // Select source codes.
    localparam logic [3:0]  SRC_REGMAP       = 4'h0;
    localparam logic [3:0]  SRC_EDGE_A0      = 4'h8;
    localparam logic [3:0]  SRC_EDGE_B1      = 4'hB;
    // Clock and sample enable divider.
    localparam int          CLK_MHZ          = 50;
    localparam int          SAMPLE_DIV       = 1;
    // Bus transfer types.
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
endpackage

/* rtl/ddcnco_top.sv */
// Behaviour
// - A 4-bit register field selects one of sixteen oscillator channels.
// - A 4-bit update index names the channel whose phase values next load.
// - Loads apply continuously or wait for a chip transfer command, per mode.
// - The tuning word is a signed two's complement phase increment.
// - Mixing frequency is word times sample rate over 2^48; 48-bit accumulator.
// - Tuning word bytes map little-endian across four consecutive byte registers.
// - Select source zero takes the active channel from the register field.
// - Edge modes count rising input edges and wrap at the select field value.
module ddcnco_top #(
    parameter int NUM_CHAN = ddcnco_pkg::NUM_CHAN
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [15:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [3:0]  gpio_in,
    output logic      [3:0]  active_channel,
    output logic      [47:0] nco_phase
);
    ////////////////////////////////////////////////////////////////////////
    // Decodes a byte address to a register index; the low two address bits are ignored.
    function automatic logic [11:0] reg_index(input logic [15:0] a);
        reg_index = a[13:2];
    endfunction

    logic        wr_pend_q;
    logic        wr_pend_d;
    logic [11:0] wr_idx_q;
    logic [11:0] wr_idx_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic [3:0]  sel_field_q;
    logic [3:0]  sel_field_d;
    logic [3:0]  src_q;
    logic [3:0]  src_d;
    logic [3:0]  upd_idx_q;
    logic [3:0]  upd_idx_d;
    logic        upd_mode_q;
    logic        upd_mode_d;
    logic [31:0] staged_q;
    logic [31:0] staged_d;
    logic [31:0] chan_inc_q [NUM_CHAN];
    logic [31:0] chan_inc_d [NUM_CHAN];
    logic        load_now;
    logic        addr_ph;
    logic [3:0]  gpio_q;
    logic [3:0]  edge_cnt_q;
    logic [3:0]  edge_cnt_d;
    logic [3:0]  active_q;
    logic [3:0]  active_d;
    logic [47:0] phase_w;
    logic [47:0] phase_q;
    logic        edge_hit;
    logic        sample_en;
    logic [7:0]  div_cnt_q;
    logic [7:0]  div_cnt_d;

    assign addr_ph   = hsel && hready && (htrans == ddcnco_pkg::HTRANS_NONSEQ ||
                                          htrans == ddcnco_pkg::HTRANS_SEQ);

    ////////////////////////////////////////////////////////////////////////
    // Sample enable divider. The accumulator steps once per sample; at the
    // default ratio of one it pulses on every clock, so the NCO runs at full rate.
    always_comb begin
        sample_en = (div_cnt_q == 8'(ddcnco_pkg::SAMPLE_DIV - 1));
        div_cnt_d = sample_en ? 8'h00 : div_cnt_q + 8'h01;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_cnt_q <= 8'h00;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave. Writes land in the data phase; zero wait states, always OKAY.
    // Reads are registered so hrdata comes straight from a flip-flop.
    always_comb begin
        wr_pend_d   = addr_ph && hwrite;
        wr_idx_d    = addr_ph ? reg_index(haddr) : wr_idx_q;
        hrdata_d    = hrdata_q;
        sel_field_d = sel_field_q;
        src_d       = src_q;
        upd_idx_d   = upd_idx_q;
        upd_mode_d  = upd_mode_q;
        staged_d    = staged_q;
        load_now    = 1'b0;
        if (addr_ph && !hwrite) begin
            case (reg_index(haddr))
                ddcnco_pkg::IDX_OSC_CTRL:     hrdata_d = {24'h000000, src_q, sel_field_q};
                ddcnco_pkg::IDX_PHASE_UPDATE: hrdata_d = {28'h0000000, upd_idx_q};
                ddcnco_pkg::IDX_TUNE_BYTE0:   hrdata_d = {24'h000000, staged_q[7:0]};
                ddcnco_pkg::IDX_TUNE_BYTE1:   hrdata_d = {24'h000000, staged_q[15:8]};
                ddcnco_pkg::IDX_TUNE_BYTE2:   hrdata_d = {24'h000000, staged_q[23:16]};
                ddcnco_pkg::IDX_TUNE_BYTE3:   hrdata_d = {24'h000000, staged_q[31:24]};
                ddcnco_pkg::IDX_XFER_CMD:     hrdata_d = {31'h00000000, upd_mode_q};
                ddcnco_pkg::IDX_STATUS:       hrdata_d = {24'h000000, edge_cnt_q, active_q};
                default:                      hrdata_d = 32'h00000000;
            endcase
        end
        if (wr_pend_q) begin
            case (wr_idx_q)
                ddcnco_pkg::IDX_OSC_CTRL: begin
                    sel_field_d = hwdata[3:0];
                    src_d       = hwdata[7:4];
                end
                ddcnco_pkg::IDX_PHASE_UPDATE: begin
                    upd_idx_d = hwdata[3:0];
                end
                // Little-endian byte lanes of the staged tuning word.
                ddcnco_pkg::IDX_TUNE_BYTE0: begin
                    staged_d[7:0] = hwdata[7:0];
                    load_now      = !upd_mode_q;
                end
                ddcnco_pkg::IDX_TUNE_BYTE1: begin
                    staged_d[15:8] = hwdata[7:0];
                    load_now       = !upd_mode_q;
                end
                ddcnco_pkg::IDX_TUNE_BYTE2: begin
                    staged_d[23:16] = hwdata[7:0];
                    load_now        = !upd_mode_q;
                end
                ddcnco_pkg::IDX_TUNE_BYTE3: begin
                    staged_d[31:24] = hwdata[7:0];
                    load_now        = !upd_mode_q;
                end
                // Bit 0 picks the mode; bit 1 is the chip transfer strobe, acting only when bit 0 is also written as one.
                ddcnco_pkg::IDX_XFER_CMD: begin
                    upd_mode_d = hwdata[0];
                    load_now   = hwdata[1] && hwdata[0];
                end
                default: begin
                    load_now = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_pend_q   <= 1'b0;
            wr_idx_q    <= 12'h000;
            hrdata_q    <= 32'h00000000;
            sel_field_q <= ddcnco_pkg::RST_FIELD;
            src_q       <= ddcnco_pkg::RST_FIELD;
            upd_idx_q   <= ddcnco_pkg::RST_FIELD;
            upd_mode_q  <= 1'b0;
            staged_q    <= 32'h00000000;
        end else begin
            wr_pend_q   <= wr_pend_d;
            wr_idx_q    <= wr_idx_d;
            hrdata_q    <= hrdata_d;
            sel_field_q <= sel_field_d;
            src_q       <= src_d;
            upd_idx_q   <= upd_idx_d;
            upd_mode_q  <= upd_mode_d;
            staged_q    <= staged_d;
        end
    end

    // Zero wait states and an OKAY answer, so ready and response never move.
    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel increment store; only the indexed channel loads.
    // Continuous mode loads the word including the byte being written this cycle.
    generate
        for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
            always_comb begin
                chan_inc_d[c] = chan_inc_q[c];
                if (load_now && upd_idx_q == 4'(c)) begin
                    chan_inc_d[c] = staged_d;
                end
            end
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    chan_inc_q[c] <= 32'h00000000;
                end else begin
                    chan_inc_q[c] <= chan_inc_d[c];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Channel choice. Edge modes count rising edges of one input pin; the pin
    // index is the low two bits of the source code.
    always_comb begin
        edge_hit   = 1'b0;
        edge_cnt_d = edge_cnt_q;
        if (src_q >= ddcnco_pkg::SRC_EDGE_A0 && src_q <= ddcnco_pkg::SRC_EDGE_B1) begin
            edge_hit = gpio_in[src_q[1:0]] && !gpio_q[src_q[1:0]];
            if (edge_hit) begin
                // Wrap to zero once the count reaches the select field value.
                edge_cnt_d = (edge_cnt_q >= sel_field_q) ? 4'h0 : edge_cnt_q + 4'h1;
            end
        end
        case (src_q)
            ddcnco_pkg::SRC_REGMAP: active_d = sel_field_q;
            4'h1:    active_d = {2'b00, gpio_in[2], gpio_in[0]};
            4'h2:    active_d = {2'b00, gpio_in[3], gpio_in[1]};
            4'h3:    active_d = {2'b00, gpio_in[1], gpio_in[0]};
            4'h4:    active_d = {2'b00, gpio_in[3], gpio_in[2]};
            4'h5:    active_d = {gpio_in[3], gpio_in[1], gpio_in[2], gpio_in[0]};
            4'h6:    active_d = gpio_in;
            4'h8, 4'h9, 4'hA, 4'hB: active_d = edge_cnt_q;
            default: active_d = sel_field_q;
        endcase
    end

    // Pins are gpio_in[0]=A0, [1]=A1, [2]=B0, [3]=B1.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gpio_q     <= 4'h0;
            edge_cnt_q <= 4'h0;
            active_q   <= ddcnco_pkg::RST_FIELD;
            phase_q    <= 48'h000000000000;
        end else begin
            gpio_q     <= gpio_in;
            edge_cnt_q <= edge_cnt_d;
            active_q   <= active_d;
            phase_q    <= phase_w;
        end
    end

    // Both outputs are flip-flops; the phase lags the accumulator by one clock.
    assign active_channel = active_q;
    assign nco_phase      = phase_q;

    ////////////////////////////////////////////////////////////////////////
    // One accumulator follows the active channel; a switch keeps phase continuous.
    ddcnco_accum #(
        .ACC_W     (ddcnco_pkg::ACC_W),
        .INC_W     (ddcnco_pkg::TUNE_W)
    ) u_accum (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .sample_en (sample_en),
        .increment (chan_inc_q[active_q]),
        .phase     (phase_w)
    );

    ////////////////////////////////////////////////////////////////////////
    AST_SEL_REGMAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        src_q == ddcnco_pkg::SRC_REGMAP |=> active_q == $past(sel_field_q))
        else $error("Register select not followed.");
    AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $past(addr_ph && !hwrite && reg_index(haddr) == ddcnco_pkg::IDX_PHASE_UPDATE)
        |-> hrdata_q[31:4] == 28'h0000000)
        else $error("Reserved bits not zero.");
    AST_CONT_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_pend_q && !upd_mode_q && wr_idx_q == ddcnco_pkg::IDX_TUNE_BYTE3)
        |=> chan_inc_q[$past(upd_idx_q)][31:24] == $past(hwdata[7:0]))
        else $error("Continuous load missed.");
    AST_HOLD_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_pend_q && upd_mode_q && wr_idx_q == ddcnco_pkg::IDX_TUNE_BYTE0)
        |=> chan_inc_q[upd_idx_q] == $past(chan_inc_q[upd_idx_q]))
        else $error("Transfer mode loaded early.");
    AST_BYTE0_LANE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_pend_q && wr_idx_q == ddcnco_pkg::IDX_TUNE_BYTE0)
        |=> staged_q[7:0] == $past(hwdata[7:0]))
        else $error("Byte 0 lane wrong.");
    AST_SEL_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_pend_q && wr_idx_q == ddcnco_pkg::IDX_OSC_CTRL)
        |=> sel_field_q == $past(hwdata[3:0]))
        else $error("Select field not written.");
    AST_IDX_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_pend_q && wr_idx_q == ddcnco_pkg::IDX_PHASE_UPDATE)
        |=> upd_idx_q == $past(hwdata[3:0]))
        else $error("Update index not written.");
    AST_EDGE_WRAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (edge_hit && edge_cnt_q >= sel_field_q) |=> edge_cnt_q == 4'h0)
        else $error("Edge counter did not wrap.");
    AST_ACC_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sample_en |=> phase_w == $past(phase_w) + {{16{$past(chan_inc_q[active_q][31])}},
                                        $past(chan_inc_q[active_q])})
        else $error("Phase step wrong.");
    AST_SRC_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_pend_q && wr_idx_q == ddcnco_pkg::IDX_OSC_CTRL)
        |=> src_q == $past(hwdata[7:4]))
        else $error("Select source not written.");
    AST_EDGE_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (edge_hit && edge_cnt_q < sel_field_q)
        |=> edge_cnt_q == $past(edge_cnt_q) + 4'h1)
        else $error("Edge counter did not advance.");
    AST_XFER_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_pend_q && wr_idx_q == ddcnco_pkg::IDX_XFER_CMD && hwdata[1:0] == 2'b11)
        |=> chan_inc_q[$past(upd_idx_q)] == $past(staged_q))
        else $error("Transfer command did not load.");
    COV_CONT: cover property (@(posedge clk_sys) load_now && !upd_mode_q);
    COV_XFER: cover property (@(posedge clk_sys) load_now && upd_mode_q);
    COV_EDGE: cover property (@(posedge clk_sys) edge_hit);
    COV_WRAP: cover property (@(posedge clk_sys) edge_hit && edge_cnt_q >= sel_field_q);
    COV_PIN_MAP: cover property (@(posedge clk_sys) src_q == 4'h5 || src_q == 4'h6);
endmodule

/* tb/tb_ddcnco_top.sv */
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_ddcnco_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys;
    logic        sys_rst;
    logic        hsel;
    logic [15:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [3:0]  gpio_in;
    logic [3:0]  active_channel;
    logic [47:0] nco_phase;
    logic [31:0] rdata;
    logic [47:0] dlt;
    int          err_count;
    int          checks_done;
    // Channel expected with inputs at 4'hD for pin sources one to six, first in the top nibble.
    localparam logic [23:0] GPIO_EXP = 24'h3213BD;

    ddcnco_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gpio_in(gpio_in),
        .active_channel(active_channel), .nco_phase(nco_phase));

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    // Free-running 50 MHz system clock.
    always #10 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks: one address phase, then a data phase, each held until ready.
    task automatic bus(input logic [11:0] idx, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {2'b00, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(idx, 1'b1, {24'h000000, d}, q);
    endtask

    task automatic rd(input logic [11:0] idx, output logic [31:0] q);
        bus(idx, 1'b0, 32'h00000000, q);
    endtask

    // Writes the low tuning word, least significant byte at the lowest index.
    task automatic tune_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            wr(ddcnco_pkg::IDX_TUNE_BYTE0 + 12'(i), w[8*i +: 8]);
        end
    endtask

    // Phase advance over ten clocks, after letting pending loads settle.
    task automatic measure(output logic [47:0] d);
        logic [47:0] p0;
        repeat (4) @(posedge clk_sys);
        p0 = nco_phase;
        repeat (10) @(posedge clk_sys);
        d = nco_phase - p0;
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs a few hundred clocks.
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        conclude();
    end

    // Main test sequence.
    initial begin
        clk_sys = 1'b0; sys_rst = 1'b1; hsel = 1'b0; haddr = 16'h0000; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h00000000; gpio_in = 4'h0;
        err_count = 0; checks_done = 0;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Every field starts at zero and the phase does not move.
        `CHK(active_channel, 4'h0)
        for (int i = 0; i < 10; i++) begin
            rd(ddcnco_pkg::IDX_OSC_CTRL + 12'(i), rdata);
            `CHK(rdata, 32'h00000000)
        end
        `CHK(nco_phase, 48'h000000000000)
        $display("test reset_values done");

        // Reserved upper bits of the phase control register ignore writes.
        wr(ddcnco_pkg::IDX_PHASE_UPDATE, 8'hFF);
        rd(ddcnco_pkg::IDX_PHASE_UPDATE, rdata);
        `CHK(rdata, 32'h0000000F)
        rd(12'h100, rdata);
        `CHK(rdata, 32'h00000000)
        $display("test reserved_bits done");

        // Register-map source: each of the sixteen channels is selectable.
        for (int c = 0; c < 16; c++) begin
            wr(ddcnco_pkg::IDX_OSC_CTRL, {4'h0, 4'(c)});
            repeat (3) @(posedge clk_sys);
            `CHK(active_channel, 4'(c))
            rd(ddcnco_pkg::IDX_STATUS, rdata);
            `CHK(rdata[3:0], 4'(c))
        end
        $display("test channel_select done");

        // Byte lanes of the tuning word read back in place.
        tune_word(32'h8877A5C3);
        for (int i = 0; i < 4; i++) begin
            rd(ddcnco_pkg::IDX_TUNE_BYTE0 + 12'(i), rdata);
            `CHK(rdata[7:0], 8'(32'h8877A5C3 >> (8 * i)))
        end
        $display("test byte_order done");

        // Continuous mode on channel 3: a negative word steps the 48-bit phase backwards.
        wr(ddcnco_pkg::IDX_OSC_CTRL, 8'h03);
        wr(ddcnco_pkg::IDX_PHASE_UPDATE, 8'h03);
        tune_word(32'h80000001);
        measure(dlt);
        `CHK(dlt, 48'hFFFB0000000A)
        // A load aimed at another channel leaves the active one alone.
        wr(ddcnco_pkg::IDX_PHASE_UPDATE, 8'h05);
        tune_word(32'h00001000);
        measure(dlt);
        `CHK(dlt, 48'hFFFB0000000A)
        $display("test continuous_update done");

        // Transfer mode: the new word waits for the transfer command.
        wr(ddcnco_pkg::IDX_PHASE_UPDATE, 8'h03);
        wr(ddcnco_pkg::IDX_XFER_CMD, 8'h01);
        tune_word(32'h00000100);
        measure(dlt);
        `CHK(dlt, 48'hFFFB0000000A)
        wr(ddcnco_pkg::IDX_XFER_CMD, 8'h03);
        measure(dlt);
        `CHK(dlt, 48'h000000000A00)
        wr(ddcnco_pkg::IDX_XFER_CMD, 8'h00);
        $display("test transfer_update done");

        // Pin-driven sources map the four inputs onto the channel number.
        gpio_in <= 4'hD;
        for (int m = 1; m <= 6; m++) begin
            wr(ddcnco_pkg::IDX_OSC_CTRL, {4'(m), 4'h0});
            repeat (3) @(posedge clk_sys);
            `CHK(active_channel, GPIO_EXP[4*(6-m) +: 4])
        end
        wr(ddcnco_pkg::IDX_OSC_CTRL, 8'h00);
        gpio_in <= 4'h0;
        $display("test pin_sources done");

        // Edge modes: only the chosen input's rising edges advance the counter.
        for (int k = 0; k < 4; k++) begin
            do_reset();
            wr(ddcnco_pkg::IDX_OSC_CTRL, {4'h8 + 4'(k), 4'h3});
            for (int e = 0; e < 2; e++) begin
                gpio_in <= 4'h1 << k;
                repeat (4) @(posedge clk_sys);
                gpio_in <= 4'h0;
                repeat (4) @(posedge clk_sys);
            end
            gpio_in <= ~(4'h1 << k);
            repeat (4) @(posedge clk_sys);
            gpio_in <= 4'h0;
            repeat (4) @(posedge clk_sys);
            rd(ddcnco_pkg::IDX_STATUS, rdata);
            `CHK(rdata[7:4], 4'h2)
            `CHK(rdata[3:0], 4'h2)
            // The third edge reaches the select value; the fourth wraps to zero.
            for (int e = 0; e < 2; e++) begin
                gpio_in <= 4'h1 << k;
                repeat (4) @(posedge clk_sys);
                gpio_in <= 4'h0;
                repeat (4) @(posedge clk_sys);
                rd(ddcnco_pkg::IDX_STATUS, rdata);
                `CHK(rdata[7:0], e == 0 ? 8'h33 : 8'h00)
            end
        end
        $display("test edge_modes done");
        conclude();
    end
endmodule
